// ### sim/host_model.sv
// Purpose: host side that loads timing registers and pulses clear or restart
// Assumes: every task is entered just after a falling edge of clock
// Notes:   valid stays up across back-to-back loads; idle drops it
`timescale 1ns/100ps
`default_nettype none
module host_model
    import sync_restart_pkg::*;
(
    // clock
    input  wire logic clock,
    // requests
    output logic      clearPulse,
    output logic      restartPulse,
    output load_req_t loadReq
);
    // ---------------------------------------------------------------
    // request tasks
    // ---------------------------------------------------------------
    initial begin
        clearPulse   = 1'b0;
        restartPulse = 1'b0;
        loadReq      = '0;
    end
    task automatic load(input logic [2:0] idx, input logic [11:0] data);
        loadReq <= '{valid: 1'b1, index: idx, data: data};
        @(negedge clock);
    endtask : load
    task automatic idle();
        loadReq.valid <= 1'b0;
        @(negedge clock);
    endtask : idle
    task automatic pulse(input logic isRestart);
        restartPulse <= isRestart;
        clearPulse   <= ~isRestart;
        @(negedge clock);
        restartPulse <= 1'b0;
        clearPulse   <= 1'b0;
    endtask : pulse
endmodule : host_model
`default_nettype wire

// ### sim/testbench.sv
// Purpose: self-checking bench for clear, enable, restart and counters
// Assumes: inputs driven and outputs sampled at the falling edge
// Notes:   short random timings keep a frame within a few hundred cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module testbench
    import sync_restart_pkg::*;
;
    logic             clock = 1'b0;
    logic             rst_n = 1'b0;
    logic             clearPulse;
    logic             restartPulse;
    load_req_t        loadReq;
    logic             hDrive;
    logic             vDrive;
    logic [CNT_W-1:0] hCount;
    logic [CNT_W-1:0] vCount;
    logic             clockEnabled;
    logic [CNT_W-1:0] hCountRun;
    logic             clockEnabledRun;
    int               n_errors = 0;
    int               checks = 0;
    int               n;
    int               r;
    logic [11:0]      he, hs, hd, ve;

    video_sync_restart_control i_dut (.clock(clock), .rst_n(rst_n), .clearPulse(clearPulse),
        .restartPulse(restartPulse), .loadReq(loadReq), .hDrive(hDrive), .vDrive(vDrive),
        .hCount(hCount), .vCount(vCount), .clockEnabled(clockEnabled));
    // second device in the clock-enabled variant, fed by the same host
    video_sync_restart_control #(.CLK_EN_RESET(1'b1)) i_dutEnabled (.clock(clock),
        .rst_n(rst_n), .clearPulse(clearPulse), .restartPulse(restartPulse), .loadReq(loadReq),
        .hDrive(), .vDrive(), .hCount(hCountRun), .vCount(), .clockEnabled(clockEnabledRun));
    host_model i_host (.clock(clock), .clearPulse(clearPulse), .restartPulse(restartPulse),
        .loadReq(loadReq));

    always #2 clock = ~clock;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // bounded: a stuck counter shows up as a wrong n, not a hang
    task automatic wait_h(input logic [11:0] v);
        n = 0;
        while (hCount !== v && n < 5000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 5000)
            n_errors++;
    endtask : wait_h
    // horizontal drive: from the first clock on line 0 only in the first frame, from start+1 later
    function automatic logic exp_h_drive(input logic first, input logic [11:0] ev, eh, hs, hd);
        if (first)
            return (ev == 12'h000) && (eh <= hd);
        return (eh > hs) && (eh <= hd);
    endfunction : exp_h_drive
    // vertical drive works on line numbers, so the end line itself is already low
    function automatic logic exp_v_drive(input logic first, input logic [11:0] ev, vs, vd);
        if (first)
            return ev < vd;
        return (ev >= vs) && (ev < vd);
    endfunction : exp_v_drive
    task automatic run_frames(input logic [11:0] he, hs, hd, ve);
        logic [11:0] eh, ev;
        logic        first;
        eh = '0;
        ev = '0;
        first = 1'b1;
        `CHK("vDriveStart", 1'b1, vDrive)
        for (int i = 0; i < 2 * (he + 1) * (ve + 1); i++) begin
            `CHK("hCount", eh, hCount)
            `CHK("vCount", ev, vCount)
            `CHK("hDrive", exp_h_drive(first, ev, eh, hs, hd), hDrive)
            `CHK("vDrive", exp_v_drive(first, ev, 12'h001, 12'h002), vDrive)
            if (eh != he) eh++;
            else begin
                eh = '0;
                first = first && (ev != ve);
                ev = (ev == ve) ? 12'h000 : ev + 12'h001;
            end
            @(negedge clock);
        end
    endtask : run_frames
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        #(4 * 20000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        n = $urandom(99032);
        repeat (10) @(negedge clock);
        rst_n <= 1'b1;
        `CHK("clockEnabled", CLK_EN_DEF, clockEnabled)
        `CHK("clockEnabledRun", 1'b1, clockEnabledRun)
        repeat (5) @(negedge clock);
        `CHK("hCountHalted", 12'h000, hCount)
        `CHK("hCountRun", 12'h005, hCountRun)
        for (r = 0; r < 3; r++) begin
            he = 12'h008 + 12'($urandom_range(7));
            hs = 12'h001 + 12'($urandom_range(2));
            hd = 12'h004 + 12'($urandom_range(3));
            ve = 12'h003 + 12'($urandom_range(2));
            i_host.load(IDX_H_END, he);
            i_host.load(IDX_H_DRV_START, hs);
            i_host.load(IDX_H_DRV_END, hd);
            i_host.load(IDX_V_END, ve);
            i_host.load(IDX_V_DRV_START, 12'h001);
            i_host.load(IDX_V_DRV_END, 12'h002);
            i_host.load(IDX_STATUS, 12'h400);
            i_host.idle();
            i_host.pulse(1'b1);
            run_frames(he, hs, hd, ve);
        end
        i_host.load(IDX_H_END, 12'h009);
        i_host.idle();
        i_host.pulse(1'b1);
        wait_h(12'h007);
        i_host.load(IDX_H_END, 12'h005);
        i_host.idle();
        wait_h(12'hFFF);
        `CHK("overrunCycles", 4086, n)
        @(negedge clock);
        `CHK("wrapToZero", 12'h000, hCount)
        i_host.pulse(1'b1);
        repeat (6) @(negedge clock);
        `CHK("restartPeriod", 12'h000, hCount)
        i_host.pulse(1'b0);
        `CHK("clearEnable", CLK_EN_DEF, clockEnabled)
        `CHK("clearEnableRun", 1'b1, clockEnabledRun)
        `CHK("clearCount", 12'h000, hCount)
        i_host.load(IDX_STATUS, 12'h400);
        i_host.idle();
        wait_h(12'h032);
        `CHK("defDriveOn", 1'b1, hDrive)
        wait_h(12'h064);
        `CHK("defDriveOff", 1'b0, hDrive)
        wait_h(H_END_DEF);
        @(negedge clock);
        `CHK("defWrap", 12'h000, hCount)
        `CHK("defLine", 12'h001, vCount)
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire

// ### verilog/sync_restart_pkg.sv
// Purpose: constants and types for the video sync restart control block
// Assumes: one clock; host loads timing registers through a load strobe
// Notes:   timing defaults are the mask values that a clear pulse restores; clock enable returns to CLK_EN_RESET

package sync_restart_pkg;

    localparam int CNT_W = 12;

    // ---------------------------------------------------------------
    // register indices on the load port
    // ---------------------------------------------------------------
    localparam logic [2:0] IDX_STATUS      = 3'h0;
    localparam logic [2:0] IDX_H_END       = 3'h1;
    localparam logic [2:0] IDX_H_DRV_START = 3'h2;
    localparam logic [2:0] IDX_H_DRV_END   = 3'h3;
    localparam logic [2:0] IDX_V_END       = 3'h4;
    localparam logic [2:0] IDX_V_DRV_START = 3'h5;
    localparam logic [2:0] IDX_V_DRV_END   = 3'h6;

    // ---------------------------------------------------------------
    // field positions and defaults
    // ---------------------------------------------------------------
    localparam int         CLK_EN_BIT      = 10;
    localparam logic       CLK_EN_DEF      = 1'b0;
    localparam logic [11:0] H_END_DEF      = 12'h38D;
    localparam logic [11:0] H_DRV_START_DEF = 12'h000;
    localparam logic [11:0] H_DRV_END_DEF  = 12'h05B;
    localparam logic [11:0] V_END_DEF      = 12'h20C;
    localparam logic [11:0] V_DRV_START_DEF = 12'h000;
    localparam logic [11:0] V_DRV_END_DEF  = 12'h00B;

    typedef struct packed {
        logic        valid;
        logic [2:0]  index;
        logic [11:0] data;
    } load_req_t;

    typedef struct packed {
        logic [11:0] hEnd;
        logic [11:0] hDrvStart;
        logic [11:0] hDrvEnd;
        logic [11:0] vEnd;
        logic [11:0] vDrvStart;
        logic [11:0] vDrvEnd;
    } timing_regs_t;

    localparam timing_regs_t TIMING_DEF = '{
        hEnd:      H_END_DEF,
        hDrvStart: H_DRV_START_DEF,
        hDrvEnd:   H_DRV_END_DEF,
        vEnd:      V_END_DEF,
        vDrvStart: V_DRV_START_DEF,
        vDrvEnd:   V_DRV_END_DEF
    };

endpackage : sync_restart_pkg

// ### verilog/video_sync_restart_control.sv
// Purpose: clear, clock enable, vectored restart and counters of a sync generator
// Assumes: all inputs synchronous to clock; clear and restart are one-cycle pulses
// Notes:   end matches are equality compares, so a lowered end value overruns
`timescale 1ns/100ps
`default_nettype none

module video_sync_restart_control
    import sync_restart_pkg::*;
#(
    parameter logic CLK_EN_RESET = CLK_EN_DEF
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // host control
    input  wire logic         clearPulse,
    input  wire logic         restartPulse,
    input  wire load_req_t    loadReq,
    // timing outputs
    output logic              hDrive,
    output logic              vDrive,
    output logic [CNT_W-1:0]  hCount,
    output logic [CNT_W-1:0]  vCount,
    output logic              clockEnabled
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    timing_regs_t      regs_q, regs_d;
    logic              clkEn_q;
    logic              firstFrame_q;
    logic              hDrive_q, vDrive_q;
    logic [CNT_W-1:0]  hCnt_q, vCnt_q;

    wire logic             running  = clkEn_q;
    wire logic [CNT_W-1:0] cntMax   = {CNT_W{1'b1}};
    wire logic             hWrap    = (hCnt_q == regs_q.hEnd) || (hCnt_q == cntMax);
    wire logic             vWrap    = (vCnt_q == regs_q.vEnd) || (vCnt_q == cntMax);
    wire logic [CNT_W-1:0] hNext    = hWrap ? '0 : hCnt_q + 12'h001;
    wire logic [CNT_W-1:0] vNext    = vWrap ? '0 : vCnt_q + 12'h001;
    wire logic             frameEnd = hWrap && vWrap;
    wire logic             hEndHit  = (hCnt_q == regs_q.hDrvEnd);
    wire logic             hStartHit = (hCnt_q == regs_q.hDrvStart) && !firstFrame_q;
    wire logic             vEndHit  = (vNext == regs_q.vDrvEnd);
    wire logic             vStartHit = (vNext == regs_q.vDrvStart) && !firstFrame_q;
    wire logic             loadHit  = loadReq.valid;

    // ---------------------------------------------------------------
    // register load path
    // ---------------------------------------------------------------
    always_comb begin
        regs_d = regs_q;
        if (loadHit) begin
            unique case (loadReq.index)
                IDX_H_END:       regs_d.hEnd      = loadReq.data;
                IDX_H_DRV_START: regs_d.hDrvStart = loadReq.data;
                IDX_H_DRV_END:   regs_d.hDrvEnd   = loadReq.data;
                IDX_V_END:       regs_d.vEnd      = loadReq.data;
                IDX_V_DRV_START: regs_d.vDrvStart = loadReq.data;
                IDX_V_DRV_END:   regs_d.vDrvEnd   = loadReq.data;
                default:         regs_d = regs_q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regs_q <= TIMING_DEF;
        end else if (clearPulse) begin
            regs_q <= TIMING_DEF;
        end else begin
            regs_q <= regs_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clkEn_q <= CLK_EN_RESET;
        end else if (clearPulse) begin
            clkEn_q <= CLK_EN_RESET;
        end else if (loadHit && loadReq.index == IDX_STATUS) begin
            clkEn_q <= loadReq.data[CLK_EN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // counters and drives
    // ---------------------------------------------------------------
    // restart zeroes counters
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hCnt_q <= '0;
            vCnt_q <= '0;
        end else if (clearPulse || restartPulse) begin
            hCnt_q <= '0;
            vCnt_q <= '0;
        end else if (running) begin
            hCnt_q <= hNext;
            vCnt_q <= hWrap ? vNext : vCnt_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hDrive_q     <= 1'b0;
            vDrive_q     <= 1'b0;
            firstFrame_q <= 1'b0;
        end else if (clearPulse) begin
            hDrive_q     <= 1'b0;
            vDrive_q     <= 1'b0;
            firstFrame_q <= 1'b0;
        end else if (restartPulse) begin
            hDrive_q     <= 1'b1;
            vDrive_q     <= 1'b1;
            firstFrame_q <= 1'b1;
        end else if (running) begin
            // end wins over start when both hit on the same count
            if (hEndHit) begin
                hDrive_q <= 1'b0;
            end else if (hStartHit) begin
                hDrive_q <= 1'b1;
            end
            if (hWrap && vEndHit) begin
                vDrive_q <= 1'b0;
            end else if (hWrap && vStartHit) begin
                vDrive_q <= 1'b1;
            end
            if (frameEnd) begin
                firstFrame_q <= 1'b0;
            end
        end
    end

    assign hDrive       = hDrive_q;
    assign vDrive       = vDrive_q;
    assign hCount       = hCnt_q;
    assign vCount       = vCnt_q;
    assign clockEnabled = clkEn_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_clear_defaults;
        @(posedge clock) disable iff (!rst_n)
        clearPulse |=> (regs_q == TIMING_DEF) && !hDrive_q && (hCnt_q == 12'h000);
    endproperty
    a_clear_defaults: assert property (p_clear_defaults)
        else $error("clear did not restore defaults");

    property p_clear_enable;
        @(posedge clock) disable iff (!rst_n)
        clearPulse |=> (clkEn_q == CLK_EN_RESET);
    endproperty
    a_clear_enable: assert property (p_clear_enable)
        else $error("enable flag wrong after clear");

    property p_halted;
        @(posedge clock) disable iff (!rst_n)
        (!clkEn_q && !clearPulse && !restartPulse)[*2] |=> $stable(hCnt_q) && $stable(vCnt_q);
    endproperty
    a_halted: assert property (p_halted)
        else $error("counters moved while clock disabled");

    property p_restart_keeps;
        @(posedge clock) disable iff (!rst_n)
        restartPulse && !clearPulse && !loadHit |=> (regs_q == $past(regs_q)) && $stable(clkEn_q);
    endproperty
    a_restart_keeps: assert property (p_restart_keeps)
        else $error("restart altered a register");

    property p_restart_drive;
        @(posedge clock) disable iff (!rst_n)
        restartPulse && !clearPulse |=> hDrive_q && vDrive_q && (hCnt_q == 12'h000)
            && (vCnt_q == 12'h000) && firstFrame_q;
    endproperty
    a_restart_drive: assert property (p_restart_drive)
        else $error("drives or counters wrong after restart");

    property p_first_end;
        @(posedge clock) disable iff (!rst_n)
        running && hEndHit && !clearPulse && !restartPulse |=> !hDrive_q;
    endproperty
    a_first_end: assert property (p_first_end)
        else $error("horizontal drive missed its end");

    property p_start_gate;
        @(posedge clock) disable iff (!rst_n)
        running && (hCnt_q == regs_q.hDrvStart) && !hEndHit && !clearPulse && !restartPulse
            |=> hDrive_q == !$past(firstFrame_q) || $past(hDrive_q);
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("horizontal drive start not gated by first frame");

    property p_overrun;
        @(posedge clock) disable iff (!rst_n)
        running && (hCnt_q > regs_q.hEnd) && (hCnt_q != cntMax) && !clearPulse && !restartPulse
            |=> hCnt_q == $past(hCnt_q) + 12'h001;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun counter did not keep counting");

    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
        running && hWrap && !clearPulse && !restartPulse |=> (hCnt_q == 12'h000);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("horizontal counter did not wrap to zero");

    property p_restart_zero;
        @(posedge clock) disable iff (!rst_n)
        restartPulse && clkEn_q && !clearPulse ##1 running && !restartPulse && !clearPulse
            |=> (hCnt_q == 12'h001);
    endproperty
    a_restart_zero: assert property (p_restart_zero)
        else $error("counting did not resume from zero after restart");

endmodule : video_sync_restart_control

`default_nettype wire
